// ===== dv/ams_sva.sv
// Checker of the serial link between host and converter ends
`timescale 1ns/10ps
module ams_sva (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Link signals
	input wire logic cfg_sel_n,
	input wire logic cfg_sclk,
	input wire logic cfg_sdata,
	input wire logic power_down_pin,
	input wire logic active_low_reset_pin
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	logic       sclk_q;
	logic [4:0] edges;

	// Counts serial clock rises inside a frame
	always_ff @(posedge sys_clk) begin
		sclk_q <= cfg_sclk;
		if (reset || cfg_sel_n) begin
			edges <= 5'h00;
		end else if (cfg_sclk && !sclk_q) begin
			edges <= edges + 5'h01;
		end
	end

	sequence s_high_half;
		cfg_sclk[*5] ##1 !cfg_sclk;
	endsequence
	sequence s_low_half;
		(!cfg_sclk)[*5];
	endsequence

	AST_HIGH_HALF: assert property ($rose(cfg_sclk) |-> s_high_half)
		else $error("serial clock high half wrong");
	AST_LOW_HALF: assert property ($fell(cfg_sclk) |-> s_low_half)
		else $error("serial clock low half wrong");
	AST_FRAME_START: assert property ($fell(cfg_sel_n) |-> s_low_half ##1 cfg_sclk)
		else $error("frame start wrong");
	AST_FRAME_LEN: assert property ($fell(cfg_sel_n) |-> ##245 $rose(cfg_sel_n))
		else $error("frame length wrong");
	AST_BIT_COUNT: assert property ($rose(cfg_sel_n) |-> edges == 5'h18)
		else $error("frame bit count wrong");
	AST_DATA_STABLE: assert property (cfg_sclk |-> $stable(cfg_sdata))
		else $error("data moved while clock high");
	AST_SCLK_IN_FRAME: assert property (cfg_sclk |-> !cfg_sel_n)
		else $error("serial clock outside frame");
	AST_SEL_GAP: assert property ($rose(cfg_sel_n) |=> cfg_sel_n)
		else $error("no gap between frames");
	AST_RESET_IDLE: assert property (disable iff (1'b0) reset |=>
		cfg_sel_n && !cfg_sclk && active_low_reset_pin && !power_down_pin)
		else $error("link not idle after reset");
endmodule

// ===== dv/test_adc_mode_power_sequencer.sv
// Testbench joining host and converter ends
`timescale 1ns/10ps
module test_adc_mode_power_sequencer;
	logic        sys_clk = 0;
	logic        reset = 1;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 0;
	logic        reg_rd = 0;
	logic [31:0] reg_rdata, rv;
	logic        powered_down, mode_pending;
	ams_pkg::ams_mode_t active_mode;
	logic [2:0]  clk_div;
	logic [15:0] bit_clk_phase;
	logic [3:0]  chan_tick, chan_route_ok, seen;
	logic [7:0]  chan_input;
	logic [15:0] words [3] = '{16'h0102, 16'h0204, 16'h0001};
	logic [7:0]  codes [4] = '{8'h02, 8'h04, 8'h08, 8'h10};
	logic [3:0]  masks [3] = '{4'h3, 4'hf, 4'h1};
	ams_pkg::ams_mode_t modes [3] = '{ams_pkg::AMS_DUAL, ams_pkg::AMS_QUAD, ams_pkg::AMS_SINGLE};
	int          fail_count = 0;
	int          checks_done = 0;
	int          cycles = 0;
	int          n;

	ams_cfg_if cfg_link ();
	ams_host ams_host_inst (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cfg(cfg_link));
	ams_device ams_device_inst (.sys_clk(sys_clk), .reset(reset), .cfg(cfg_link),
		.powered_down(powered_down), .active_mode(active_mode), .clk_div(clk_div),
		.mode_pending(mode_pending), .bit_clk_phase(bit_clk_phase), .chan_tick(chan_tick),
		.chan_input(chan_input), .chan_route_ok(chan_route_ok));
	ams_sva ams_sva_inst (.sys_clk(sys_clk), .reset(reset), .cfg_sel_n(cfg_link.cfg_sel_n),
		.cfg_sclk(cfg_link.cfg_sclk), .cfg_sdata(cfg_link.cfg_sdata),
		.power_down_pin(cfg_link.power_down_pin),
		.active_low_reset_pin(cfg_link.active_low_reset_pin));

	// Clock and hang limit
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			fail_count++;
			summarize();
		end
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// One serial write, then wait for the device to show it
	task automatic send(input logic [7:0] a, input logic [15:0] d);
		wr(4'h0, {24'h0, a});
		wr(4'h4, {16'h0, d});
		for (int i = 0; i < 400; i++) begin
			rd(4'hc, rv);
			if (rv[0] === 1'b0) break;
		end
		chk("busy", rv[0], 1'b0);
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("mode", active_mode, ams_pkg::AMS_SINGLE);
		chk("div", clk_div, 3'h1);
		rd(4'h8, rv);
		chk("pins", rv, 32'h2);
		rd(4'h2, rv);
		chk("unmapped", rv, 32'h0);
		$display("reset test done");
		wr(4'h8, 32'h0);
		wr(4'h8, 32'h3);
		repeat (3) @(posedge sys_clk);
		chk("pd pin", powered_down, 1'b1);
		send(8'h42, 16'h5a3c);
		chk("phase", bit_clk_phase, 16'h5a3c);
		rd(4'h0, rv);
		chk("addr", rv, 32'h42);
		for (int m = 0; m < 3; m++) begin
			send(8'h31, words[m]);
			wr(4'h8, 32'h2);
			repeat (3) @(posedge sys_clk);
			chk("mode", active_mode, modes[m]);
			chk("div", clk_div, words[m][2:0]);
			n = 0;
			seen = 4'h0;
			repeat (8) begin
				@(posedge sys_clk);
				#1 n += chan_tick[0];
				seen |= chan_tick;
			end
			chk("ticks", n, 8 / words[m][2:0]);
			chk("chans", seen, masks[m]);
			if (m < 2) wr(4'h8, 32'h3);
		end
		$display("mode test done");
		send(8'h31, 16'h0204);
		chk("mode", active_mode, ams_pkg::AMS_SINGLE);
		chk("pending", mode_pending, 1'b1);
		send(8'h0f, 16'h0200);
		chk("pd reg", powered_down, 1'b1);
		chk("mode", active_mode, ams_pkg::AMS_QUAD);
		send(8'h0f, 16'h0000);
		chk("pd reg", powered_down, 1'b0);
		$display("power test done");
		send(8'h3a, 16'h1008);
		send(8'h3b, 16'h0402);
		chk("route", chan_input, 8'h1b);
		chk("ok", chan_route_ok, 4'hf);
		chk("pd", powered_down, 1'b0);
		for (int k = 0; k < 4; k++) begin
			send(8'h3a, {codes[k], codes[k]});
			chk("route", chan_input[3:0], {k[1:0], k[1:0]});
		end
		send(8'h3a, 16'h0300);
		chk("ok", chan_route_ok, 4'hc);
		$display("routing test done");
		send(8'h00, 16'h0001);
		chk("mode", active_mode, ams_pkg::AMS_SINGLE);
		chk("phase", bit_clk_phase, 16'h0);
		chk("ok", chan_route_ok, 4'hf);
		send(8'h42, 16'h00a5);
		chk("phase", bit_clk_phase, 16'h00a5);
		wr(4'h8, 32'h0);
		wr(4'h8, 32'h2);
		repeat (3) @(posedge sys_clk);
		chk("phase", bit_clk_phase, 16'h0);
		wr(4'h8, 32'h3);
		send(8'h31, 16'h0003);
		chk("mode", active_mode, ams_pkg::AMS_SINGLE);
		chk("div", clk_div, 3'h1);
		$display("soft reset test done");
		summarize();
	end
endmodule

// ===== src/ams_cfg_if.sv
// Serial configuration link and control pins between host and converter
`timescale 1ns/10ps
interface ams_cfg_if;
	logic cfg_sel_n;            // Frame select, low during a frame
	logic cfg_sclk;             // Serial clock, data taken on its rising edge
	logic cfg_sdata;            // Serial data, top bit first
	logic power_down_pin;       // High holds the converter powered down
	logic active_low_reset_pin; // Low resets the converter

	modport host (
		output cfg_sel_n,
		output cfg_sclk,
		output cfg_sdata,
		output power_down_pin,
		output active_low_reset_pin
	);

	modport device (
		input cfg_sel_n,
		input cfg_sclk,
		input cfg_sdata,
		input power_down_pin,
		input active_low_reset_pin
	);
endinterface

// ===== src/ams_consts.svh
// Constants of the converter mode and power sequencer
`ifndef AMS_CONSTS_SVH
`define AMS_CONSTS_SVH

// Serial frame: 8-bit address then 16-bit data, first bit is the top one
`define AMS_FRAME_BITS      5'd24
`define AMS_LAST_BIT        5'd23

// Device register addresses
`define AMS_A_RESET         8'h00
`define AMS_A_POWER         8'h0f
`define AMS_A_MODE          8'h31
`define AMS_A_SEL_A         8'h3a
`define AMS_A_SEL_B         8'h3b
`define AMS_A_PHASE         8'h42

// Device fields and values
`define AMS_SOFT_RESET_BIT  0
`define AMS_PD_BIT          9
`define AMS_MODE_SINGLE     16'h0001
`define AMS_MODE_DUAL       16'h0102
`define AMS_MODE_QUAD       16'h0204

// Device reset values
`define AMS_POWER_RST       16'h0000
`define AMS_MODE_RST        16'h0001
`define AMS_SEL_RST         16'h0202
`define AMS_PHASE_RST       16'h0000

// One-hot input codes in a channel byte
`define AMS_IN_ONE          8'h02
`define AMS_IN_TWO          8'h04
`define AMS_IN_THREE        8'h08
`define AMS_IN_FOUR         8'h10

// Channel masks per mode
`define AMS_MASK_SINGLE     4'h1
`define AMS_MASK_DUAL       4'h3
`define AMS_MASK_QUAD       4'hf

// Host register offsets
`define AMS_H_ADDR          4'h0
`define AMS_H_DATA          4'h4
`define AMS_H_PINS          4'h8
`define AMS_H_STATUS        4'hc
`define AMS_H_PINS_RST      2'h2

// Serial clock timing: half period as a least time, rounded up to cycles
`define AMS_CLK_NS          40
`define AMS_HALF_NS         200
`define AMS_HALF_CYC        ((`AMS_HALF_NS + `AMS_CLK_NS - 1) / `AMS_CLK_NS)

`endif

// ===== src/ams_device.sv
// Converter end: serial register file, power and mode sequencing, input routing
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`include "ams_consts.svh"
module ams_device (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         reset,
	// Link from the host
	ams_cfg_if.device         cfg,
	// Converter state
	output logic              powered_down,
	output ams_pkg::ams_mode_t active_mode,
	output logic      [2:0]   clk_div,
	output logic              mode_pending,
	output logic      [15:0]  bit_clk_phase,
	// Sampling and routing
	output logic      [3:0]   chan_tick,
	output logic      [7:0]   chan_input,
	output logic      [3:0]   chan_route_ok
);

	logic [23:0] rx_shift_reg;
	logic [4:0]  rx_cnt_reg;
	logic        sclk_prev_reg;
	logic        sel_prev_reg;
	logic        soft_rst_reg;
	logic [15:0] power_reg;
	logic [15:0] mode_reg;
	logic [15:0] sel_a_reg;
	logic [15:0] sel_b_reg;
	logic [2:0]  div_cnt_reg;
	logic [3:0]  chan_mask_reg;
	logic        sclk_rise;
	logic        commit;
	logic [7:0]  wr_addr;
	logic [15:0] wr_data;
	logic        chip_rst;
	logic        pd_now;
	logic        tick;
	logic [2:0]  route_c1;
	logic [2:0]  route_c2;
	logic [2:0]  route_c3;
	logic [2:0]  route_c4;

	// Valid mode word: only the three documented combinations
	function automatic logic mode_ok(input logic [15:0] v);
		mode_ok = (v == `AMS_MODE_SINGLE) || (v == `AMS_MODE_DUAL) || (v == `AMS_MODE_QUAD);
	endfunction

	// One-hot channel byte to a two-bit input index and a valid flag
	function automatic logic [2:0] route_of(input logic [7:0] b);
		if (b == `AMS_IN_ONE) begin
			route_of = 3'b100;
		end else if (b == `AMS_IN_TWO) begin
			route_of = 3'b101;
		end else if (b == `AMS_IN_THREE) begin
			route_of = 3'b110;
		end else if (b == `AMS_IN_FOUR) begin
			route_of = 3'b111;
		end else begin
			route_of = 3'b000;
		end
	endfunction

	// Serial edge and frame end, seen on rising sys_clk edges only
	assign sclk_rise = cfg.cfg_sclk & ~sclk_prev_reg;
	assign commit    = cfg.cfg_sel_n & ~sel_prev_reg & (rx_cnt_reg == `AMS_FRAME_BITS);
	assign wr_addr   = rx_shift_reg[23:16];
	assign wr_data   = rx_shift_reg[15:0];
	// Reset pin, reset command or system reset clear the device
	assign chip_rst  = reset | ~cfg.active_low_reset_pin | soft_rst_reg;
	// Power down by pin or register bit
	assign pd_now    = cfg.power_down_pin | power_reg[`AMS_PD_BIT];
	// No clock format selection exists anywhere in the map
	assign tick      = (div_cnt_reg == clk_div - 3'h1);
	// Decoded channel bytes: valid flag on top, input index below
	assign route_c1  = route_of(sel_a_reg[15:8]);
	assign route_c2  = route_of(sel_a_reg[7:0]);
	assign route_c3  = route_of(sel_b_reg[15:8]);
	assign route_c4  = route_of(sel_b_reg[7:0]);

	// Edge history of the link
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sclk_prev_reg <= 1'b0;
			sel_prev_reg  <= 1'b1;
		end else begin
			sclk_prev_reg <= cfg.cfg_sclk;
			sel_prev_reg  <= cfg.cfg_sel_n;
		end
	end

	// Frame receiver: shifts bits while selected, counts up to a full frame
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rx_shift_reg <= 24'h000000;
			rx_cnt_reg   <= 5'h00;
		end else if (!sel_prev_reg && cfg.cfg_sel_n) begin
			rx_cnt_reg <= rx_cnt_reg;                      // Held for the commit test
		end else if (cfg.cfg_sel_n) begin
			rx_cnt_reg <= 5'h00;
		end else if (sclk_rise) begin
			rx_shift_reg <= {rx_shift_reg[22:0], cfg.cfg_sdata};
			if (rx_cnt_reg != 5'h1f) begin
				rx_cnt_reg <= rx_cnt_reg + 5'h01;          // Long frames saturate and fail
			end
		end
	end

	// Reset command pulse, one cycle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			soft_rst_reg <= 1'b0;
		end else begin
			soft_rst_reg <= commit && wr_addr == `AMS_A_RESET && wr_data[`AMS_SOFT_RESET_BIT];
		end
	end

	// Register file, written when a full frame ends
	always_ff @(posedge sys_clk) begin
		if (chip_rst) begin
			power_reg     <= `AMS_POWER_RST;
			mode_reg      <= `AMS_MODE_RST;
			sel_a_reg     <= `AMS_SEL_RST;
			sel_b_reg     <= `AMS_SEL_RST;
			bit_clk_phase <= `AMS_PHASE_RST;
		end else if (commit) begin
			if (wr_addr == `AMS_A_POWER) begin
				power_reg <= wr_data;
			end else if (wr_addr == `AMS_A_MODE) begin
				mode_reg <= wr_data;
			end else if (wr_addr == `AMS_A_SEL_A) begin
				sel_a_reg <= wr_data;
			end else if (wr_addr == `AMS_A_SEL_B) begin
				sel_b_reg <= wr_data;
			end else if (wr_addr == `AMS_A_PHASE) begin
				bit_clk_phase <= wr_data;
			end
		end
	end

	// Power state follows pin and register bit
	always_ff @(posedge sys_clk) begin
		if (chip_rst) begin
			powered_down <= 1'b0;
		end else begin
			powered_down <= pd_now;
		end
	end

	// Mode and divider are taken only while powered down, for synchronisation
	always_ff @(posedge sys_clk) begin
		if (chip_rst) begin
			active_mode   <= ams_pkg::AMS_SINGLE;
			clk_div       <= 3'h1;
			chan_mask_reg <= `AMS_MASK_SINGLE;
		end else if (pd_now && mode_ok(mode_reg)) begin
			clk_div <= mode_reg[2:0];
			if (mode_reg == `AMS_MODE_DUAL) begin
				active_mode   <= ams_pkg::AMS_DUAL;
				chan_mask_reg <= `AMS_MASK_DUAL;
			end else if (mode_reg == `AMS_MODE_QUAD) begin
				active_mode   <= ams_pkg::AMS_QUAD;
				chan_mask_reg <= `AMS_MASK_QUAD;
			end else begin
				active_mode   <= ams_pkg::AMS_SINGLE;
				chan_mask_reg <= `AMS_MASK_SINGLE;
			end
		end
	end

	// Written mode not yet in force because the device is still active
	always_ff @(posedge sys_clk) begin
		if (chip_rst) begin
			mode_pending <= 1'b0;
		end else begin
			mode_pending <= mode_ok(mode_reg) && (mode_reg[2:0] != clk_div) && !pd_now;
		end
	end

	// Clock divider: one sample per divider count on each active channel
	always_ff @(posedge sys_clk) begin
		if (chip_rst || pd_now || tick) begin
			div_cnt_reg <= 3'h0;
		end else begin
			div_cnt_reg <= div_cnt_reg + 3'h1;
		end
	end

	// Per-channel sample strobes
	always_ff @(posedge sys_clk) begin
		if (chip_rst || pd_now) begin
			chan_tick <= 4'h0;
		end else begin
			chan_tick <= tick ? chan_mask_reg : 4'h0;
		end
	end

	// Routing follows the select registers with no power down needed
	always_ff @(posedge sys_clk) begin
		if (chip_rst) begin
			chan_input    <= 8'h00;
			chan_route_ok <= 4'h0;
		end else begin
			chan_input    <= {route_c4[1:0], route_c3[1:0], route_c2[1:0], route_c1[1:0]};
			chan_route_ok <= {route_c4[2], route_c3[2], route_c2[2], route_c1[2]};
		end
	end

endmodule

// ===== src/ams_host.sv
// Host end: sends serial register writes and drives the control pins
`timescale 1ns/10ps
`include "ams_consts.svh"
module ams_host (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// Software register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Link to the converter
	ams_cfg_if.host          cfg
);

	ams_pkg::ams_tx_state_t state_reg;
	logic [7:0]  cmd_addr_reg;
	logic [23:0] shift_reg;
	logic [4:0]  bit_cnt_reg;
	logic [2:0]  half_cnt_reg;
	logic [1:0]  pins_reg;
	logic        half_tick;
	logic        start;

	// Half period of the serial clock as a one-cycle enable
	assign half_tick = (half_cnt_reg == 3'(`AMS_HALF_CYC - 1));
	// A data write launches a frame only when the link is idle
	assign start = reg_wr && (reg_addr == `AMS_H_DATA) && (state_reg == ams_pkg::AMS_TX_IDLE);

	// Half period divider, runs only inside a frame
	always_ff @(posedge sys_clk) begin
		if (reset || state_reg == ams_pkg::AMS_TX_IDLE || half_tick) begin
			half_cnt_reg <= 3'h0;
		end else begin
			half_cnt_reg <= half_cnt_reg + 3'h1;
		end
	end

	// Target address of the next frame
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cmd_addr_reg <= 8'h00;
		end else if (reg_wr && reg_addr == `AMS_H_ADDR) begin
			cmd_addr_reg <= reg_wdata[7:0];
		end
	end

	// Power-down and reset pin levels set by software
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pins_reg <= `AMS_H_PINS_RST;
		end else if (reg_wr && reg_addr == `AMS_H_PINS) begin
			pins_reg <= reg_wdata[1:0];
		end
	end

	// Pins leave straight from flip-flops
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cfg.power_down_pin       <= 1'b0;
			cfg.active_low_reset_pin <= 1'b1;
		end else begin
			cfg.power_down_pin       <= pins_reg[0];
			cfg.active_low_reset_pin <= pins_reg[1];
		end
	end

	// Frame sender: address byte then data word, top bit first
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_reg     <= ams_pkg::AMS_TX_IDLE;
			shift_reg     <= 24'h000000;
			bit_cnt_reg   <= 5'h00;
			cfg.cfg_sel_n <= 1'b1;
			cfg.cfg_sclk  <= 1'b0;
			cfg.cfg_sdata <= 1'b0;
		end else begin
			case (state_reg)
				ams_pkg::AMS_TX_IDLE: begin
					if (start) begin
						shift_reg     <= {cmd_addr_reg, reg_wdata[15:0]};
						bit_cnt_reg   <= 5'h00;
						cfg.cfg_sel_n <= 1'b0;
						cfg.cfg_sdata <= cmd_addr_reg[7];
						state_reg     <= ams_pkg::AMS_TX_LOW;
					end
				end
				ams_pkg::AMS_TX_LOW: begin
					if (half_tick) begin
						cfg.cfg_sclk <= 1'b1;
						state_reg    <= ams_pkg::AMS_TX_HIGH;
					end
				end
				ams_pkg::AMS_TX_HIGH: begin
					if (half_tick) begin
						cfg.cfg_sclk <= 1'b0;
						if (bit_cnt_reg == `AMS_LAST_BIT) begin
							state_reg <= ams_pkg::AMS_TX_TRAIL;
						end else begin
							shift_reg     <= {shift_reg[22:0], 1'b0};
							cfg.cfg_sdata <= shift_reg[22];
							bit_cnt_reg   <= bit_cnt_reg + 5'h01;
							state_reg     <= ams_pkg::AMS_TX_LOW;
						end
					end
				end
				ams_pkg::AMS_TX_TRAIL: begin
					if (half_tick) begin
						cfg.cfg_sel_n <= 1'b1;
						state_reg     <= ams_pkg::AMS_TX_IDLE;
					end
				end
				default: state_reg <= ams_pkg::AMS_TX_IDLE;
			endcase
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			if (reg_addr == `AMS_H_ADDR) begin
				reg_rdata <= {24'h000000, cmd_addr_reg};
			end else if (reg_addr == `AMS_H_PINS) begin
				reg_rdata <= {30'h00000000, pins_reg};
			end else if (reg_addr == `AMS_H_STATUS) begin
				reg_rdata <= {31'h00000000, state_reg != ams_pkg::AMS_TX_IDLE};
			end else begin
				reg_rdata <= 32'h00000000;
			end
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

endmodule

// ===== src/ams_pkg.sv
// Types of the converter mode and power sequencer
package ams_pkg;

	typedef enum logic [1:0] {
		AMS_SINGLE = 2'b00,
		AMS_DUAL   = 2'b01,
		AMS_QUAD   = 2'b10
	} ams_mode_t;

	typedef enum logic [1:0] {
		AMS_TX_IDLE  = 2'b00,
		AMS_TX_LOW   = 2'b01,
		AMS_TX_HIGH  = 2'b10,
		AMS_TX_TRAIL = 2'b11
	} ams_tx_state_t;

endpackage
